/* File: rtl/pc_peak_monitor_parity_mask.sv */
// Program counter peak monitor and data memory zero parity mask registers.
`timescale 1ns/1ps
module pc_peak_monitor_parity_mask #(
  parameter int PC_W = pc_peak_pkg::PC_W,
  parameter int SUBS = pc_peak_pkg::SUBS
) (
  // Clock and reset.
  input  wire logic                           clk_i,
  input  wire logic                           sys_rst_i,
  // Register port.
  input  wire pc_peak_pkg::reg_req_t          reg_req_i,
  output logic [pc_peak_pkg::DATA_W-1:0]      rd_data_o,
  // Core program counter and frame or block boundary.
  input  wire logic [PC_W-1:0]                pc_value_i,
  input  wire logic                           frame_start_i,
  output logic                                pc_clear_o,
  // Parity errors in and panic reports out.
  input  wire logic [SUBS-1:0]                parity_err_i,
  output logic [SUBS-1:0]                     parity_panic_o,
  // Interrupt.
  output logic                                irq_o
);

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic [PC_W-1:0] max_pc(input logic [PC_W-1:0] a,
                                             input logic [PC_W-1:0] b);
    return (a > b) ? a : b;
  endfunction : max_pc

  localparam int LOW_W = pc_peak_pkg::DATA_W;

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  logic                                  clear_bit;
  logic [PC_W-1:0]                       running_peak;
  logic [PC_W-1:0]                       frame_peak;
  logic [PC_W-1:0]                       alltime_peak;
  logic [pc_peak_pkg::DATA_W-1:0]        banks_lo_ignore;
  logic [pc_peak_pkg::DATA_W-1:0]        banks_hi_ignore;
  logic [pc_peak_pkg::EV_W-1:0]          irq_status;
  logic [pc_peak_pkg::EV_W-1:0]          irq_enable;
  logic [pc_peak_pkg::EV_W-1:0]          next_irq_status;
  logic [pc_peak_pkg::EV_W-1:0]          next_irq_enable;
  logic [pc_peak_pkg::EV_W-1:0]          events;
  logic [pc_peak_pkg::DATA_W-1:0]        next_rd_data;
  logic [PC_W-1:0]                       boundary_peak;
  logic                                  parity_any;
  logic                                  wr_en;
  logic                                  rd_en;
  logic [pc_peak_pkg::ADDR_W-1:0]        addr;
  logic [pc_peak_pkg::DATA_W-1:0]        wdata;
  logic [SUBS-1:0]                       ignore_all;

  assign wr_en = reg_req_i.wr;
  assign rd_en = reg_req_i.rd;
  assign addr  = reg_req_i.addr;
  assign wdata = reg_req_i.wdata;

  // Peak at the boundary cycle includes the value the core shows in that cycle.
  assign boundary_peak = max_pc(running_peak, pc_value_i);

  // Flat ignore vector, one bit for each bank and subbank pair.
  assign ignore_all = pc_peak_pkg::ignore_vector(banks_lo_ignore, banks_hi_ignore);

  // ---------------------------------------------------------------------------
  // Clear control
  // ---------------------------------------------------------------------------
  // The bit is a level: while it is set the core counter and all trackers hold
  // zero, so a set-then-clear sequence restarts maximum tracking.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      clear_bit <= 1'b0;
    end else if (wr_en && addr == pc_peak_pkg::PEAK_CLEAR_OFS) begin
      clear_bit <= wdata[pc_peak_pkg::CLEAR_BIT];
    end
  end

  // Drives the core counter clear and freeze straight from the register.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pc_clear_o <= 1'b0;
    end else if (wr_en && addr == pc_peak_pkg::PEAK_CLEAR_OFS) begin
      pc_clear_o <= wdata[pc_peak_pkg::CLEAR_BIT];
    end
  end

  // ---------------------------------------------------------------------------
  // Peak tracking
  // ---------------------------------------------------------------------------
  // Running peak restarts from the boundary cycle's counter value.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || clear_bit) begin
      running_peak <= '0;
    end else if (frame_start_i) begin
      running_peak <= pc_value_i;
    end else begin
      running_peak <= boundary_peak;
    end
  end

  // Frame peak only changes at a boundary or a clear, so software sees a stable value.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || clear_bit) begin
      frame_peak <= '0;
    end else if (frame_start_i) begin
      frame_peak <= boundary_peak;
    end
  end

  // All-time peak only ever rises until software clears it.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || clear_bit) begin
      alltime_peak <= '0;
    end else if (frame_start_i) begin
      alltime_peak <= max_pc(alltime_peak, boundary_peak);
    end
  end

  // ---------------------------------------------------------------------------
  // Parity ignore registers
  // ---------------------------------------------------------------------------
  // Reserved bits are not stored and read back as zero.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      banks_lo_ignore <= pc_peak_pkg::RESET_VALUE;
    end else if (wr_en && addr == pc_peak_pkg::BANKS_LO_MASK_OFS) begin
      banks_lo_ignore <= wdata & pc_peak_pkg::MASK_FIELDS;
    end
  end

  // Banks 3 and 2 share the second register, with the same layout.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      banks_hi_ignore <= pc_peak_pkg::RESET_VALUE;
    end else if (wr_en && addr == pc_peak_pkg::BANKS_HI_MASK_OFS) begin
      banks_hi_ignore <= wdata & pc_peak_pkg::MASK_FIELDS;
    end
  end

  // Filter stage between the memories and the panic logic.
  parity_mask_filter #(
    .SUBS (SUBS)
  ) i_parity_mask_filter (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .err_i     (parity_err_i),
    .ignore_i  (ignore_all),
    .panic_o   (parity_panic_o),
    .any_o     (parity_any)
  );

  // ---------------------------------------------------------------------------
  // Interrupt status and enable
  // ---------------------------------------------------------------------------
  // A new all-time peak, a forwarded parity error and a boundary are events.
  always_comb begin
    events                        = '0;
    events[pc_peak_pkg::EV_PEAK]   = frame_start_i && !clear_bit &&
                                     (boundary_peak > alltime_peak);
    events[pc_peak_pkg::EV_PARITY] = parity_any;
    events[pc_peak_pkg::EV_FRAME]  = frame_start_i;
  end

  // Reading status clears it, but an event in the same cycle still wins.
  always_comb begin
    next_irq_status = irq_status;
    if (rd_en && addr == pc_peak_pkg::IRQ_STATUS_OFS) begin
      next_irq_status = '0;
    end
    next_irq_status = next_irq_status | events;
  end

  // A set enable bit lets the matching status bit drive the interrupt.
  always_comb begin
    next_irq_enable = irq_enable;
    if (wr_en && addr == pc_peak_pkg::IRQ_ENABLE_OFS) begin
      next_irq_enable = wdata[pc_peak_pkg::EV_W-1:0];
    end
  end

  // Status and enable registers.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      irq_status <= '0;
      irq_enable <= '0;
    end else begin
      irq_status <= next_irq_status;
      irq_enable <= next_irq_enable;
    end
  end

  // Computed from next values so the level tracks status and enable exactly.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(next_irq_status & next_irq_enable);
    end
  end

  // ---------------------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------------------
  // Unmapped addresses and idle cycles return zero.
  always_comb begin
    next_rd_data = '0;
    if (rd_en) begin
      case (addr)
        pc_peak_pkg::PEAK_CLEAR_OFS:    next_rd_data[pc_peak_pkg::CLEAR_BIT] = clear_bit;
        pc_peak_pkg::FRAME_HIGH_OFS:
          next_rd_data[pc_peak_pkg::HIGH_W-1:0] = frame_peak[PC_W-1:LOW_W];
        pc_peak_pkg::FRAME_LOW_OFS:     next_rd_data = frame_peak[LOW_W-1:0];
        pc_peak_pkg::ALLTIME_HIGH_OFS:
          next_rd_data[pc_peak_pkg::HIGH_W-1:0] = alltime_peak[PC_W-1:LOW_W];
        pc_peak_pkg::ALLTIME_LOW_OFS:   next_rd_data = alltime_peak[LOW_W-1:0];
        pc_peak_pkg::BANKS_LO_MASK_OFS: next_rd_data = banks_lo_ignore;
        pc_peak_pkg::BANKS_HI_MASK_OFS: next_rd_data = banks_hi_ignore;
        pc_peak_pkg::IRQ_STATUS_OFS:    next_rd_data[pc_peak_pkg::EV_W-1:0] = irq_status;
        pc_peak_pkg::IRQ_ENABLE_OFS:    next_rd_data[pc_peak_pkg::EV_W-1:0] = irq_enable;
        default:                        next_rd_data = '0;
      endcase
    end
  end

  // Read data stand for exactly one cycle, since idle cycles load zero.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rd_data_o <= '0;
    end else begin
      rd_data_o <= next_rd_data;
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  // Frame peak takes the boundary maximum one cycle later.
  frame_transfer_a: assert property (
    frame_start_i && !clear_bit |=> frame_peak == $past(boundary_peak))
    else $error("Frame peak did not capture the boundary maximum.");

  // All-time peak never falls while the clear bit stays low.
  alltime_rises_a: assert property (
    !clear_bit ##1 !clear_bit |-> alltime_peak >= $past(alltime_peak))
    else $error("All-time peak fell without a clear.");

  // Setting the clear bit zeroes every tracker within two cycles.
  clear_zeroes_a: assert property (
    wr_en && addr == pc_peak_pkg::PEAK_CLEAR_OFS && wdata[pc_peak_pkg::CLEAR_BIT]
    |=> ##1 (running_peak == '0 && frame_peak == '0 && alltime_peak == '0))
    else $error("Clear bit did not zero the peak trackers.");

  // Upper all-time read shows bits 23:16 and zero above.
  alltime_high_read_a: assert property (
    rd_en && addr == pc_peak_pkg::ALLTIME_HIGH_OFS |=>
    rd_data_o == {{(LOW_W-pc_peak_pkg::HIGH_W){1'b0}}, $past(alltime_peak[PC_W-1:LOW_W])})
    else $error("All-time high read is wrong.");

  // Writes never change the read-only frame peak low register.
  frame_low_ro_a: assert property (
    wr_en && addr == pc_peak_pkg::FRAME_LOW_OFS && !frame_start_i && !clear_bit
    |=> frame_peak == $past(frame_peak))
    else $error("Write changed a read-only peak.");

  // A mask write reads back with the reserved bits at zero.
  mask_readback_a: assert property (
    (wr_en && addr == pc_peak_pkg::BANKS_LO_MASK_OFS) ##1
    (rd_en && addr == pc_peak_pkg::BANKS_LO_MASK_OFS) |=>
    rd_data_o == ($past(wdata, 2) & pc_peak_pkg::MASK_FIELDS))
    else $error("Mask register read back wrong.");

  // Panic output is the raw error with ignored subbanks removed.
  panic_filter_a: assert property (
    ##1 parity_panic_o ==
    $past(parity_err_i & ~ignore_all))
    else $error("Panic output does not match mask filter.");

  // Right after reset all trackers and masks are zero.
  reset_zero_a: assert property (
    $past(sys_rst_i) |-> (alltime_peak == '0 && frame_peak == '0 &&
                          banks_lo_ignore == '0 && banks_hi_ignore == '0))
    else $error("Registers not zero after reset.");

  // Core clear output follows the clear bit.
  core_clear_a: assert property (
    pc_clear_o == clear_bit)
    else $error("Core clear output differs from clear bit.");

  // After release, tracking restarts from zero at the next boundary.
  restart_track_a: assert property (
    $fell(clear_bit) && !frame_start_i |-> alltime_peak == '0)
    else $error("All-time peak not reset by set-then-clear.");

  // Interrupt level equals unmasked status.
  irq_level_a: assert property (
    irq_o == |(irq_status & irq_enable))
    else $error("Interrupt level wrong.");

  // Boundary maximum above the all-time peak raises it.
  alltime_raise_a: assert property (
    frame_start_i && !clear_bit && boundary_peak > alltime_peak
    |=> alltime_peak == $past(boundary_peak) && irq_status[pc_peak_pkg::EV_PEAK])
    else $error("All-time peak not raised at boundary.");

  // A status read clears every bit that no event sets again in that cycle.
  status_clear_a: assert property (
    rd_en && addr == pc_peak_pkg::IRQ_STATUS_OFS |=> irq_status == $past(events))
    else $error("Status read did not clear the status bits.");

  // An event always leaves its status bit set, even beside a clearing read.
  status_sticky_a: assert property (
    events != '0 |=> (irq_status & $past(events)) == $past(events))
    else $error("Event did not set its status bit.");

  // A clear-register write reaches the core clear output at the next edge.
  clear_write_a: assert property (
    wr_en && addr == pc_peak_pkg::PEAK_CLEAR_OFS |=>
    pc_clear_o == $past(wdata[pc_peak_pkg::CLEAR_BIT]))
    else $error("Core clear output did not follow the clear write.");

  // Lower frame read shows the low half of the frame peak.
  frame_low_read_a: assert property (
    rd_en && addr == pc_peak_pkg::FRAME_LOW_OFS |=>
    rd_data_o == $past(frame_peak[LOW_W-1:0]))
    else $error("Frame peak low read is wrong.");

  // Idle cycles leave zero on the read data.
  idle_read_zero_a: assert property (
    !rd_en |=> rd_data_o == '0)
    else $error("Read data not zero after an idle cycle.");

  new_peak_c:    cover property (frame_start_i && boundary_peak > alltime_peak);
  panic_c:       cover property (|parity_panic_o);
  clear_cycle_c: cover property (clear_bit ##1 !clear_bit ##[1:20] frame_start_i);
  irq_c:         cover property ($rose(irq_o));

endmodule : pc_peak_monitor_parity_mask

/* File: rtl/pc_peak_pkg.sv */
// Constants, register map and carrier types of the peak monitor and parity mask bank.
package pc_peak_pkg;

  // ---------------------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------------------
  localparam int PC_W         = 24;
  localparam int DATA_W       = 16;
  localparam int ADDR_W       = 16;
  localparam int HIGH_W       = 8;
  localparam int SUB_PER_BANK = 5;
  localparam int BANKS        = 4;
  localparam int SUBS         = BANKS * SUB_PER_BANK;

  // ---------------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] PEAK_CLEAR_OFS     = 16'hF462;
  localparam logic [ADDR_W-1:0] FRAME_HIGH_OFS     = 16'hF463;
  localparam logic [ADDR_W-1:0] FRAME_LOW_OFS      = 16'hF464;
  localparam logic [ADDR_W-1:0] ALLTIME_HIGH_OFS   = 16'hF465;
  localparam logic [ADDR_W-1:0] ALLTIME_LOW_OFS    = 16'hF466;
  localparam logic [ADDR_W-1:0] BANKS_LO_MASK_OFS  = 16'hF467;
  localparam logic [ADDR_W-1:0] BANKS_HI_MASK_OFS  = 16'hF468;
  localparam logic [ADDR_W-1:0] IRQ_STATUS_OFS     = 16'hF470;
  localparam logic [ADDR_W-1:0] IRQ_ENABLE_OFS     = 16'hF471;

  // ---------------------------------------------------------------------------
  // Fields and reset values
  // ---------------------------------------------------------------------------
  localparam int                CLEAR_BIT      = 0;
  localparam int                LOWER_BANK_LSB = 0;
  localparam int                UPPER_BANK_LSB = 8;
  localparam logic [DATA_W-1:0] MASK_FIELDS    = 16'h1F1F;
  localparam logic [DATA_W-1:0] RESET_VALUE    = 16'h0000;

  // Interrupt event bits.
  localparam int EV_W      = 3;
  localparam int EV_PEAK   = 0;
  localparam int EV_PARITY = 1;
  localparam int EV_FRAME  = 2;

  // Register port request carried as one bundle.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_t;

  // Spread two mask registers over the flat subbank vector, bank-major.
  function automatic logic [SUBS-1:0] ignore_vector(input logic [DATA_W-1:0] lo,
                                                    input logic [DATA_W-1:0] hi);
    logic [SUBS-1:0] v;
    v = {hi[UPPER_BANK_LSB +: SUB_PER_BANK], hi[LOWER_BANK_LSB +: SUB_PER_BANK],
         lo[UPPER_BANK_LSB +: SUB_PER_BANK], lo[LOWER_BANK_LSB +: SUB_PER_BANK]};
    return v;
  endfunction : ignore_vector

endpackage : pc_peak_pkg

/* File: rtl/parity_mask_filter.sv */
// Registered parity error filter that drops errors of ignored subbanks.
`timescale 1ns/1ps
module parity_mask_filter #(
  parameter int SUBS = pc_peak_pkg::SUBS
) (
  // Clock and reset.
  input  wire logic            clk_i,
  input  wire logic            sys_rst_i,
  // Raw errors and ignore bits.
  input  wire logic [SUBS-1:0] err_i,
  input  wire logic [SUBS-1:0] ignore_i,
  // Filtered errors.
  output logic      [SUBS-1:0] panic_o,
  output logic                 any_o
);

  // ---------------------------------------------------------------------------
  // Filter
  // ---------------------------------------------------------------------------
  // A register stage keeps the panic path off the register-port decode timing.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      panic_o <= '0;
      any_o   <= 1'b0;
    end else begin
      panic_o <= err_i & ~ignore_i;
      any_o   <= |(err_i & ~ignore_i);
    end
  end

  // A masked subbank never reaches the panic outputs.
  masked_drop_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ##1 (panic_o & $past(ignore_i)) == '0)
    else $error("Ignored subbank error reached panic output.");

endmodule : parity_mask_filter

/* File: testbench/pc_peak_monitor_parity_mask_tb.sv */
// Self-checking testbench of the peak monitor and parity mask register bank.
`timescale 1ns/1ps
module pc_peak_monitor_parity_mask_tb;

  // ---------------------------------------------------------------------------
  // Stimulus and observed signals
  // ---------------------------------------------------------------------------
  logic                  clk_i         = 1'b0;
  logic                  sys_rst_i     = 1'b1;
  pc_peak_pkg::reg_req_t req           = '0;
  logic [23:0]           pc_value      = 24'h000000;
  logic                  frame_start   = 1'b0;
  logic [19:0]           parity_err    = 20'h00000;
  logic [15:0]           rd_data;
  logic                  pc_clear;
  logic [19:0]           parity_panic;
  logic                  irq;
  int                    error_cnt     = 0;
  int                    n_compared    = 0;

  // Clock of 8 ns period.
  always #4 clk_i = ~clk_i;

  // ---------------------------------------------------------------------------
  // Device under test
  // ---------------------------------------------------------------------------
  pc_peak_monitor_parity_mask i_pc_peak_monitor_parity_mask (
    .clk_i          (clk_i),
    .sys_rst_i      (sys_rst_i),
    .reg_req_i      (req),
    .rd_data_o      (rd_data),
    .pc_value_i     (pc_value),
    .frame_start_i  (frame_start),
    .pc_clear_o     (pc_clear),
    .parity_err_i   (parity_err),
    .parity_panic_o (parity_panic),
    .irq_o          (irq)
  );

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  // Four-state compare so that an unknown never passes.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  // One-cycle write strobe, released at the edge that takes it.
  task automatic wr(input logic [15:0] addr, input logic [15:0] data);
    @(posedge clk_i);
    req.addr  <= addr;
    req.wdata <= data;
    req.wr    <= 1'b1;
    @(posedge clk_i);
    req.wr    <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so sample just after that edge.
  task automatic rd_chk(input logic [15:0] addr, input logic [15:0] exp);
    @(posedge clk_i);
    req.addr <= addr;
    req.rd   <= 1'b1;
    @(posedge clk_i);
    req.rd   <= 1'b0;
    #1;
    check({16'h0000, rd_data}, {16'h0000, exp});
  endtask : rd_chk

  // Write, then read in the very next cycle, with no gap between the strobes.
  task automatic wr_rd_chk(input logic [15:0] addr, input logic [15:0] data,
                           input logic [15:0] exp);
    @(posedge clk_i);
    req.addr  <= addr;
    req.wdata <= data;
    req.wr    <= 1'b1;
    @(posedge clk_i);
    req.wr    <= 1'b0;
    req.rd    <= 1'b1;
    @(posedge clk_i);
    req.rd    <= 1'b0;
    #1;
    check({16'h0000, rd_data}, {16'h0000, exp});
  endtask : wr_rd_chk

  // Hold one program counter value for one cycle, with or without a boundary.
  task automatic pc_step(input logic [23:0] value, input logic boundary);
    @(posedge clk_i);
    pc_value    <= value;
    frame_start <= boundary;
  endtask : pc_step

  // One cycle of raw parity errors, then the registered panic one cycle later.
  task automatic err_pulse(input logic [19:0] errs, input logic [19:0] exp);
    @(posedge clk_i);
    parity_err <= errs;
    @(posedge clk_i);
    parity_err <= 20'h00000;
    #1;
    check({12'h000, parity_panic}, {12'h000, exp});
  endtask : err_pulse

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  // Reset values, an unmapped place and a write to the read-only frame peak low.
  task automatic reset_scn();
    rd_chk(16'hF464, 16'h0000);
    rd_chk(16'hF465, 16'h0000);
    rd_chk(16'hF466, 16'h0000);
    rd_chk(16'hF467, 16'h0000);
    rd_chk(16'hF468, 16'h0000);
    wr(16'hF46F, 16'hFFFF);
    rd_chk(16'hF46F, 16'h0000);
    wr(16'hF464, 16'hFFFF);
    rd_chk(16'hF464, 16'h0000);
    err_pulse(20'hFFFFF, 20'hFFFFF);
  endtask : reset_scn

  // Two frames: the second has a lower peak, so only the frame peak falls.
  task automatic peak_scn();
    pc_step(24'h000100, 1'b0);
    pc_step(24'h123456, 1'b0);
    pc_step(24'h000050, 1'b0);
    pc_step(24'h00000A, 1'b1);
    pc_step(24'h000000, 1'b0);
    rd_chk(16'hF463, 16'h0012);
    rd_chk(16'hF464, 16'h3456);
    rd_chk(16'hF465, 16'h0012);
    rd_chk(16'hF466, 16'h3456);
    pc_step(24'h000200, 1'b0);
    pc_step(24'h000005, 1'b1);
    pc_step(24'h000000, 1'b0);
    rd_chk(16'hF463, 16'h0000);
    rd_chk(16'hF464, 16'h0200);
    wr(16'hF465, 16'hFFFF);
    wr(16'hF466, 16'hFFFF);
    rd_chk(16'hF465, 16'h0012);
    rd_chk(16'hF466, 16'h3456);
  endtask : peak_scn

  // Clear set, a boundary ignored while set, then release restarts tracking.
  task automatic clear_scn();
    wr(16'hF462, 16'h0001);
    @(posedge clk_i);
    #1;
    check({31'h0, pc_clear}, 32'h1);
    pc_step(24'h999999, 1'b1);
    pc_step(24'h000000, 1'b0);
    rd_chk(16'hF462, 16'h0001);
    rd_chk(16'hF464, 16'h0000);
    rd_chk(16'hF465, 16'h0000);
    rd_chk(16'hF466, 16'h0000);
    wr(16'hF462, 16'hFFFE);
    @(posedge clk_i);
    #1;
    check({31'h0, pc_clear}, 32'h0);
    rd_chk(16'hF462, 16'h0000);
    pc_step(24'h000077, 1'b0);
    pc_step(24'h000001, 1'b1);
    pc_step(24'h000000, 1'b0);
    rd_chk(16'hF464, 16'h0077);
    rd_chk(16'hF465, 16'h0000);
    rd_chk(16'hF466, 16'h0077);
  endtask : clear_scn

  // Each subbank ignored alone, reserved bits, then the parity interrupt.
  task automatic parity_scn();
    logic [15:0] addr;
    logic [15:0] bits;
    for (int i = 0; i < 20; i++) begin
      addr = (i < 10) ? 16'hF467 : 16'hF468;
      bits = 16'h0001 << (((i / 5) % 2) * 8 + (i % 5));
      wr(addr, bits);
      err_pulse(20'hFFFFF, ~(20'h00001 << i));
      wr(addr, 16'h0000);
    end
    wr(16'hF467, 16'hFFFF);
    wr(16'hF468, 16'hA5A5);
    rd_chk(16'hF467, 16'h1F1F);
    rd_chk(16'hF468, 16'h0505);
    err_pulse(20'hFFFFF, 20'hD6800);
    wr_rd_chk(16'hF467, 16'hE3E7, 16'h0307);
    wr(16'hF467, 16'h0000);
    wr(16'hF468, 16'h0000);
    // Earlier scenarios left a new peak, parity errors and boundaries pending.
    rd_chk(16'hF470, 16'h0007);
    wr(16'hF471, 16'h0002);
    err_pulse(20'h00001, 20'h00001);
    repeat (2) @(posedge clk_i);
    #1;
    check({31'h0, irq}, 32'h1);
    rd_chk(16'hF470, 16'h0002);
    @(posedge clk_i);
    #1;
    check({31'h0, irq}, 32'h0);
    wr(16'hF467, 16'h0001);
    err_pulse(20'h00001, 20'h00000);
    repeat (2) @(posedge clk_i);
    #1;
    check({31'h0, irq}, 32'h0);
  endtask : parity_scn

  // ---------------------------------------------------------------------------
  // Verdict and run control
  // ---------------------------------------------------------------------------
  task automatic complete_run();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run

  // The whole sequence needs well under a thousand cycles.
  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    complete_run();
  end

  // Main sequence.
  initial begin
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    reset_scn();
    peak_scn();
    clear_scn();
    parity_scn();
    complete_run();
  end

endmodule : pc_peak_monitor_parity_mask_tb
